// *** hw/btbcc_pkg.sv ***
// Constants, encodings and state enumeration of the toggle/branch/call/clear decode unit
package btbcc_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;

    // ****************************************************************
    // Instruction encodings
    // ****************************************************************
    localparam logic [3:0] OP_TOGGLE = 4'h7;
    localparam logic [6:0] OP_CLEAR = 7'h35;
    localparam logic [7:0] OP_BRA_OVF = 8'hE4;
    localparam logic [7:0] OP_BRA_ZERO = 8'hE0;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [3:0] OP_CALL_WORD2 = 4'hF;

    // ****************************************************************
    // Addressing
    // ****************************************************************
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

    // ****************************************************************
    // Instruction cycle phases and program counter steps
    // ****************************************************************
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] RET_EXTRA = 21'h000002;

    // ****************************************************************
    // Status and control bit positions
    // ****************************************************************
    localparam int STAT_Z = 2;
    localparam int STAT_OV = 3;
    localparam int STAT_W = 5;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EXT = 1;

    // ****************************************************************
    // Register indices on the software port
    // ****************************************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_BANK = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_WORK = 4'h3;
    localparam logic [3:0] REG_PC = 4'h4;
    localparam logic [3:0] REG_TOS = 4'h5;
    localparam logic [3:0] REG_WSHAD = 4'h6;
    localparam logic [3:0] REG_SSHAD = 4'h7;
    localparam logic [3:0] REG_BSHAD = 4'h8;
    localparam logic [3:0] REG_EXEC = 4'h9;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [7:0] WORK_RST = 8'h00;

    // Execution state of the current instruction cycle
    typedef enum logic [1:0] {EX_RUN, EX_FLUSH, EX_CALL2} btbcc_exec_e;
endpackage

// *** hw/btbcc_addr_resolve.sv ***
// Data address resolution: access bank, banked and indexed literal offset forms
`timescale 1ns/1ps
module btbcc_addr_resolve #(
    parameter int AW = 12
) (
    input wire logic bank_bit,
    input wire logic [7:0] reg_addr,
    input wire logic [3:0] bank_sel,
    input wire logic ext_en,
    input wire logic [AW-1:0] index_base,
    output logic [AW-1:0] data_addr,
    output logic indexed
);
    // ****************************************************************
    // Address selection
    // ****************************************************************
    // Indexed form only for the low access window, so upper SFR space stays reachable
    always_comb begin
        indexed = !bank_bit && ext_en && (reg_addr <= btbcc_pkg::INDEXED_MAX);
        if (indexed) begin
            data_addr = index_base + {{(AW-8){1'b0}}, reg_addr};
        end else if (bank_bit) begin
            data_addr = {bank_sel, reg_addr};
        end else if (reg_addr <= btbcc_pkg::INDEXED_MAX) begin
            data_addr = {btbcc_pkg::ACCESS_LO_BANK, reg_addr};
        end else begin
            data_addr = {btbcc_pkg::ACCESS_HI_BANK, reg_addr};
        end
    end
endmodule // btbcc_addr_resolve

// *** hw/btbcc_core.sv ***
// Decode and execute unit for toggle, conditional branch, call and clear instructions
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module btbcc_core (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic [20:0] PROG_ADDR,
    input wire logic [15:0] PROG_DATA,
    output logic [11:0] DMEM_ADDR,
    output logic DMEM_RD,
    input wire logic [7:0] DMEM_RDATA,
    output logic DMEM_WR,
    output logic [7:0] DMEM_WDATA,
    input wire logic [11:0] INDEX_BASE,
    output logic STACK_PUSH,
    output logic [20:0] STACK_DATA,
    output logic [1:0] INSTR_PHASE
);
    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        logic [1:0] ph;
        btbcc_pkg::btbcc_exec_e exec;
        btbcc_pkg::btbcc_exec_e next;
        logic [15:0] ir;
        logic [7:0] k_low;
        logic [20:0] pc;
        logic [20:0] top_of_stack;
        logic [7:0] work;
        logic [4:0] status;
        logic [3:0] bank;
        logic [7:0] work_shad;
        logic [4:0] status_shad;
        logic [3:0] bank_shad;
        logic [1:0] ctrl;
        logic [11:0] dmem_addr;
        logic dmem_rd;
        logic dmem_wr;
        logic [7:0] dmem_wdata;
        logic push;
        logic [31:0] reg_rdata;
    } btbcc_state_s;

    btbcc_state_s s_q;
    btbcc_state_s s_d;
    logic [15:0] cur;
    logic is_toggle;
    logic is_clear;
    logic is_bra_ovf;
    logic is_bra_zero;
    logic is_call;
    logic [11:0] res_addr;
    logic res_indexed;
    logic [20:0] bra_offset;
    logic [7:0] bit_mask;

    // ****************************************************************
    // Decode
    // ****************************************************************
    // In Q1 the word on the program port is decoded directly so the data read starts in Q2
    assign cur = (s_q.ph == btbcc_pkg::PH_Q1) ? PROG_DATA : s_q.ir;
    assign is_toggle = (cur[15:12] == btbcc_pkg::OP_TOGGLE);
    assign is_clear = (cur[15:9] == btbcc_pkg::OP_CLEAR);
    assign is_bra_ovf = (cur[15:8] == btbcc_pkg::OP_BRA_OVF);
    assign is_bra_zero = (cur[15:8] == btbcc_pkg::OP_BRA_ZERO);
    assign is_call = (cur[15:9] == btbcc_pkg::OP_CALL);
    assign bra_offset = {{12{s_q.ir[7]}}, s_q.ir[7:0], 1'b0};
    assign bit_mask = 8'h01 << s_q.ir[11:9];

    btbcc_addr_resolve #(
        .AW(btbcc_pkg::DADDR_W)
    ) u_resolve (
        .bank_bit(cur[8]),
        .reg_addr(cur[7:0]),
        .bank_sel(s_q.bank),
        .ext_en(s_q.ctrl[btbcc_pkg::CTRL_EXT]),
        .index_base(INDEX_BASE),
        .data_addr(res_addr),
        .indexed(res_indexed)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Software writes come first so that hardware updates in the same cycle win
    always_comb begin
        s_d = s_q;
        s_d.dmem_rd = 1'b0;
        s_d.dmem_wr = 1'b0;
        s_d.push = 1'b0;
        s_d.reg_rdata = 32'h00000000;
        if (REG_WR) begin
            case (REG_ADDR)
                btbcc_pkg::REG_CTRL: begin
                    s_d.ctrl = REG_WDATA[1:0];
                    // A fresh start begins a clean instruction cycle, so no half-done step resumes
                    if (!s_q.ctrl[btbcc_pkg::CTRL_RUN]) begin
                        s_d.ph = btbcc_pkg::PH_Q1;
                        s_d.exec = btbcc_pkg::EX_RUN;
                        s_d.next = btbcc_pkg::EX_RUN;
                    end
                end
                btbcc_pkg::REG_BANK: s_d.bank = REG_WDATA[3:0];
                btbcc_pkg::REG_STATUS: s_d.status = REG_WDATA[4:0];
                btbcc_pkg::REG_WORK: s_d.work = REG_WDATA[7:0];
                btbcc_pkg::REG_PC: begin
                    // PC may only be moved while halted, otherwise a fetch would tear
                    if (!s_q.ctrl[btbcc_pkg::CTRL_RUN]) begin
                        s_d.pc = {REG_WDATA[20:1], 1'b0};
                    end
                end
                default: ;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                btbcc_pkg::REG_CTRL: s_d.reg_rdata = {30'h00000000, s_q.ctrl};
                btbcc_pkg::REG_BANK: s_d.reg_rdata = {28'h0000000, s_q.bank};
                btbcc_pkg::REG_STATUS: s_d.reg_rdata = {27'h0000000, s_q.status};
                btbcc_pkg::REG_WORK: s_d.reg_rdata = {24'h000000, s_q.work};
                btbcc_pkg::REG_PC: s_d.reg_rdata = {11'h000, s_q.pc};
                btbcc_pkg::REG_TOS: s_d.reg_rdata = {11'h000, s_q.top_of_stack};
                btbcc_pkg::REG_WSHAD: s_d.reg_rdata = {24'h000000, s_q.work_shad};
                btbcc_pkg::REG_SSHAD: s_d.reg_rdata = {27'h0000000, s_q.status_shad};
                btbcc_pkg::REG_BSHAD: s_d.reg_rdata = {28'h0000000, s_q.bank_shad};
                btbcc_pkg::REG_EXEC: s_d.reg_rdata = {28'h0000000, s_q.ph, s_q.exec};
                default: s_d.reg_rdata = 32'h00000000;
            endcase
        end
        // Four clocks make one instruction cycle while running
        if (s_q.ctrl[btbcc_pkg::CTRL_RUN]) begin
            s_d.ph = s_q.ph + 2'h1;
            case (s_q.ph)
                btbcc_pkg::PH_Q1: begin
                    case (s_q.exec)
                        btbcc_pkg::EX_RUN: begin
                            s_d.ir = PROG_DATA;
                            s_d.pc = s_q.pc + btbcc_pkg::PC_STEP;
                            if (is_toggle || is_clear) begin
                                s_d.dmem_addr = res_addr;
                                s_d.dmem_rd = 1'b1;
                            end
                        end
                        btbcc_pkg::EX_CALL2: begin
                            s_d.ir = PROG_DATA;
                            s_d.pc = s_q.pc + btbcc_pkg::PC_STEP;
                        end
                        default: begin
                            // Idle cycle: the word on the program port is dropped, PC holds
                            s_d.ir = s_q.ir;
                        end
                    endcase
                end
                btbcc_pkg::PH_Q3: begin
                    case (s_q.exec)
                        btbcc_pkg::EX_RUN: begin
                            if (is_toggle) begin
                                s_d.dmem_wdata = DMEM_RDATA ^ bit_mask;
                                s_d.dmem_wr = 1'b1;
                            end
                            if (is_clear) begin
                                s_d.dmem_wdata = 8'h00;
                                s_d.dmem_wr = 1'b1;
                                s_d.status[btbcc_pkg::STAT_Z] = 1'b1;
                            end
                            // PC already points past the branch, so adding 2n gives PC+2+2n
                            if ((is_bra_ovf && s_q.status[btbcc_pkg::STAT_OV]) ||
                                (is_bra_zero && s_q.status[btbcc_pkg::STAT_Z])) begin
                                s_d.pc = s_q.pc + bra_offset;
                                s_d.next = btbcc_pkg::EX_FLUSH;
                            end
                            if (is_call) begin
                                s_d.top_of_stack = s_q.pc + btbcc_pkg::RET_EXTRA;
                                s_d.push = 1'b1;
                                s_d.k_low = s_q.ir[7:0];
                                s_d.next = btbcc_pkg::EX_CALL2;
                                if (s_q.ir[8]) begin
                                    s_d.work_shad = s_q.work;
                                    s_d.status_shad = s_q.status;
                                    s_d.bank_shad = s_q.bank;
                                end
                            end
                        end
                        btbcc_pkg::EX_CALL2: begin
                            // A second word without its prefix leaves PC at the next word
                            if (s_q.ir[15:12] == btbcc_pkg::OP_CALL_WORD2) begin
                                s_d.pc = {s_q.ir[11:0], s_q.k_low, 1'b0};
                            end
                            s_d.next = btbcc_pkg::EX_RUN;
                        end
                        default: s_d.next = btbcc_pkg::EX_RUN;
                    endcase
                end
                btbcc_pkg::PH_Q4: begin
                    s_d.exec = s_q.next;
                    s_d.next = btbcc_pkg::EX_RUN;
                end
                default: ;
            endcase
        end
        // Synchronous reset to the documented idle values
        if (!RST_N) begin
            s_d = '0;
            s_d.ctrl = btbcc_pkg::CTRL_RST;
            s_d.pc = btbcc_pkg::PC_RST;
            s_d.bank = btbcc_pkg::BANK_RST;
            s_d.status = btbcc_pkg::STATUS_RST;
            s_d.work = btbcc_pkg::WORK_RST;
            s_d.exec = btbcc_pkg::EX_RUN;
            s_d.next = btbcc_pkg::EX_RUN;
        end
    end

    // State register
    always_ff @(posedge CLOCK) begin
        s_q <= s_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // All outputs come straight from the state record
    assign REG_RDATA = s_q.reg_rdata;
    assign PROG_ADDR = s_q.pc;
    assign DMEM_ADDR = s_q.dmem_addr;
    assign DMEM_RD = s_q.dmem_rd;
    assign DMEM_WR = s_q.dmem_wr;
    assign DMEM_WDATA = s_q.dmem_wdata;
    assign STACK_PUSH = s_q.push;
    assign STACK_DATA = s_q.top_of_stack;
    assign INSTR_PHASE = s_q.ph;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    logic ex_run_q4;
    logic br_taken_q4;
    assign ex_run_q4 = (s_q.ph == btbcc_pkg::PH_Q4) && (s_q.exec == btbcc_pkg::EX_RUN);
    assign br_taken_q4 = ex_run_q4 && (s_q.next == btbcc_pkg::EX_FLUSH);

    // Toggle writes back the read byte with exactly one bit flipped
    toggle_bit_a: assert property (DMEM_WR && ex_run_q4 && (s_q.ir[15:12] == btbcc_pkg::OP_TOGGLE)
        |-> (DMEM_WDATA == ($past(DMEM_RDATA) ^ bit_mask)))
        else $error("toggle result is not the read byte with one bit inverted");

    banked_addr_a: assert property ((s_q.ph == btbcc_pkg::PH_Q2) && DMEM_RD && s_q.ir[8]
        |-> (DMEM_ADDR == {s_q.bank, s_q.ir[7:0]}))
        else $error("banked access does not use the bank select register");

    indexed_addr_a: assert property ((s_q.ph == btbcc_pkg::PH_Q2) && DMEM_RD && !s_q.ir[8]
        && s_q.ctrl[btbcc_pkg::CTRL_EXT] && (s_q.ir[7:0] <= btbcc_pkg::INDEXED_MAX)
        |-> (DMEM_ADDR == INDEX_BASE + {4'h0, s_q.ir[7:0]}))
        else $error("indexed literal offset address is wrong");

    ovf_gate_a: assert property (ex_run_q4 && (s_q.ir[15:8] == btbcc_pkg::OP_BRA_OVF)
        |-> (br_taken_q4 == $past(s_q.status[btbcc_pkg::STAT_OV], 2)))
        else $error("overflow branch taken against the flag");

    zero_gate_a: assert property (ex_run_q4 && (s_q.ir[15:8] == btbcc_pkg::OP_BRA_ZERO)
        |-> (br_taken_q4 == $past(s_q.status[btbcc_pkg::STAT_Z], 2)))
        else $error("zero branch taken against the flag");

    branch_target_a: assert property (br_taken_q4
        |-> (PROG_ADDR == $past(s_q.pc, 2) + bra_offset))
        else $error("branch target is not PC plus 2 plus 2n");

    // A taken branch spends one full idle cycle with PC frozen
    sequence flush_cycle_s;
        (s_q.exec == btbcc_pkg::EX_FLUSH) && $stable(PROG_ADDR) [*4];
    endsequence
    sequence back_to_run_s;
        (s_q.exec == btbcc_pkg::EX_RUN) && (s_q.ph == btbcc_pkg::PH_Q1);
    endsequence
    flush_len_a: assert property (br_taken_q4 ##1 1'b1 |-> flush_cycle_s ##1 back_to_run_s)
        else $error("taken branch idle cycle has wrong length or moves PC");

    push_value_a: assert property (STACK_PUSH |-> (STACK_DATA == s_q.pc + btbcc_pkg::RET_EXTRA))
        else $error("pushed return address is not call address plus four");

    shadow_copy_a: assert property (STACK_PUSH && s_q.ir[8]
        |-> (s_q.work_shad == $past(s_q.work)) && (s_q.bank_shad == $past(s_q.bank)))
        else $error("shadow registers not loaded by a call with save");

    shadow_hold_a: assert property (STACK_PUSH && !s_q.ir[8] |-> $stable(s_q.work_shad))
        else $error("shadow register changed by a call without save");

    // Call target lands one instruction cycle after the push
    sequence call_second_s;
        (s_q.exec == btbcc_pkg::EX_CALL2) [*4];
    endsequence
    call_load_a: assert property (STACK_PUSH ##1 call_second_s
        |-> ((s_q.ir[15:12] != btbcc_pkg::OP_CALL_WORD2)
            || (PROG_ADDR == {s_q.ir[11:0], s_q.k_low, 1'b0})))
        else $error("call did not load the 20-bit target in its second cycle");

    clear_reg_a: assert property (DMEM_WR && ex_run_q4 && (s_q.ir[15:9] == btbcc_pkg::OP_CLEAR)
        |-> (DMEM_WDATA == 8'h00) && s_q.status[btbcc_pkg::STAT_Z])
        else $error("clear did not write zero and set the zero flag");
endmodule // btbcc_core

// *** sim/bit_toggle_branch_call_clear_decode_bench.sv ***
// Self-checking bench for the toggle/branch/call/clear decode unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module bit_toggle_branch_call_clear_decode_bench;
    // ****************************************************************
    // Stimulus signals, memories and fetch trace
    // ****************************************************************
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [31:0] REG_WDATA = 32'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic [20:0] PROG_ADDR;
    logic [15:0] PROG_DATA = 16'h0000;
    logic [11:0] DMEM_ADDR;
    logic DMEM_RD;
    logic [7:0] DMEM_RDATA = 8'h00;
    logic DMEM_WR;
    logic [7:0] DMEM_WDATA;
    logic [11:0] INDEX_BASE = 12'h200;
    logic STACK_PUSH;
    logic [20:0] STACK_DATA;
    logic [1:0] INSTR_PHASE;
    logic [15:0] prog [256];
    logic [7:0] dmem [4096];
    logic [20:0] trace [$];
    logic mon = 1'b0;
    logic [31:0] rv;
    int pushes = 0;
    int fails = 0;
    int checked = 0;

    btbcc_core u_btbcc_core (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
        .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD), .DMEM_RDATA(DMEM_RDATA), .DMEM_WR(DMEM_WR),
        .DMEM_WDATA(DMEM_WDATA), .INDEX_BASE(INDEX_BASE), .STACK_PUSH(STACK_PUSH), .STACK_DATA(STACK_DATA),
        .INSTR_PHASE(INSTR_PHASE));

    // 25 ns clock
    initial begin
        forever #12.5 CLOCK = ~CLOCK;
    end

    // Program and data memories answer one edge late; a stale word is harmless since PC settles early
    always @(posedge CLOCK) begin
        PROG_DATA <= prog[PROG_ADDR[8:1]];
        if (DMEM_RD) DMEM_RDATA <= dmem[DMEM_ADDR];
        if (DMEM_WR) dmem[DMEM_ADDR] <= DMEM_WDATA;
        if (STACK_PUSH) pushes <= pushes + 1;
        if (mon && INSTR_PHASE === btbcc_pkg::PH_Q1) trace.push_back(PROG_ADDR);
    end

    // ****************************************************************
    // Bus and run helpers
    // ****************************************************************
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look just after that edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask

    task automatic clr_prog();
        for (int i = 0; i < 256; i++) prog[i] = 16'h0000;
    endtask

    // Run until n instruction fetches were seen; trailing zero words act as no-ops
    task automatic run(input logic ext, input int n);
        wr(btbcc_pkg::REG_CTRL, {30'h0, ext, 1'b1});
        mon <= 1'b1;
        for (int i = 0; i < 100 && trace.size() < n; i++) @(posedge CLOCK);
        mon <= 1'b0;
        wr(btbcc_pkg::REG_CTRL, {30'h0, ext, 1'b0});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_toggle_clear();
        rd(btbcc_pkg::REG_PC, rv);
        `CHK("pc after reset", 32'h0, rv)
        clr_prog();
        prog[0] = 16'h7921;
        prog[1] = 16'h7080;
        prog[2] = 16'h6A10;
        dmem[12'h321] = 8'h75;
        dmem[12'hF80] = 8'h00;
        dmem[12'h010] = 8'h5A;
        wr(btbcc_pkg::REG_BANK, 32'h3);
        trace.delete();
        run(1'b0, 4);
        `CHK("toggle banked", 8'h65, dmem[12'h321])
        `CHK("toggle access high", 8'h01, dmem[12'hF80])
        `CHK("clear data", 8'h00, dmem[12'h010])
        rd(btbcc_pkg::REG_STATUS, rv);
        `CHK("zero flag", 1'b1, rv[btbcc_pkg::STAT_Z])
        `CHK("third fetch", 21'h000004, trace[2])
    endtask

    // Extended set on: 5Fh is the last indexed address, 60h falls back to the access bank
    task automatic t_indexed();
        clr_prog();
        prog[8] = 16'h7E5F;
        prog[9] = 16'h7E60;
        dmem[12'h25F] = 8'h0F;
        dmem[12'hF60] = 8'h01;
        wr(btbcc_pkg::REG_PC, 32'h10);
        trace.delete();
        run(1'b1, 3);
        `CHK("indexed toggle", 8'h8F, dmem[12'h25F])
        `CHK("boundary not indexed", 8'h81, dmem[12'hF60])
    endtask

    task automatic t_branch();
        clr_prog();
        prog[8'h20] = 16'hE403;
        prog[8'h21] = 16'h6A11;
        prog[8'h24] = 16'hE080;
        dmem[12'h011] = 8'h77;
        wr(btbcc_pkg::REG_STATUS, 32'h08);
        wr(btbcc_pkg::REG_PC, 32'h40);
        trace.delete();
        run(1'b0, 4);
        `CHK("overflow taken idle", 21'h000048, trace[1])
        `CHK("overflow target", 21'h000048, trace[2])
        `CHK("zero not taken", 21'h00004A, trace[3])
        `CHK("flushed word", 8'h77, dmem[12'h011])
        clr_prog();
        prog[8'h80] = 16'hE405;
        prog[8'h81] = 16'hE080;
        wr(btbcc_pkg::REG_STATUS, 32'h04);
        wr(btbcc_pkg::REG_PC, 32'h100);
        trace.delete();
        run(1'b0, 4);
        `CHK("overflow not taken", 21'h000102, trace[1])
        `CHK("zero back -128", 21'h000004, trace[2])
        `CHK("zero target", 21'h000004, trace[3])
    endtask

    task automatic t_call();
        clr_prog();
        prog[8'h10] = 16'hED45;
        prog[8'h11] = 16'hF123;
        wr(btbcc_pkg::REG_STATUS, 32'h0A);
        wr(btbcc_pkg::REG_WORK, 32'hC3);
        wr(btbcc_pkg::REG_BANK, 32'h6);
        wr(btbcc_pkg::REG_PC, 32'h20);
        pushes = 0;
        trace.delete();
        run(1'b0, 3);
        `CHK("call second word", 21'h000022, trace[1])
        `CHK("call target", 21'h02468A, trace[2])
        `CHK("push count", 1, pushes)
        `CHK("stack data", 21'h000024, STACK_DATA)
        rd(btbcc_pkg::REG_TOS, rv);
        `CHK("top of stack", 32'h24, rv)
        rd(btbcc_pkg::REG_WSHAD, rv);
        `CHK("work shadow", 32'hC3, rv)
        rd(btbcc_pkg::REG_SSHAD, rv);
        `CHK("status shadow", 32'h0A, rv)
        rd(btbcc_pkg::REG_BSHAD, rv);
        `CHK("bank shadow", 32'h6, rv)
        clr_prog();
        prog[8'h18] = 16'hEC10;
        prog[8'h19] = 16'hF000;
        wr(btbcc_pkg::REG_WORK, 32'h11);
        wr(btbcc_pkg::REG_PC, 32'h30);
        trace.delete();
        run(1'b0, 3);
        `CHK("short call target", 21'h000020, trace[2])
        rd(btbcc_pkg::REG_TOS, rv);
        `CHK("second top of stack", 32'h34, rv)
        rd(btbcc_pkg::REG_WSHAD, rv);
        `CHK("shadow kept", 32'hC3, rv)
    endtask

    // ****************************************************************
    // Verdict, watchdog and main sequence
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; twenty thousand means a hang
    initial begin
        #500000;
        fails++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'b1;
        t_toggle_clear();
        t_indexed();
        t_branch();
        t_call();
        close_out();
    end
endmodule // bit_toggle_branch_call_clear_decode_bench
